// file: design/plc_filter.sv
// per-line glitch filter: a level passes once stable for a fixed count
`include "plc_params.svh"
module plc_filter #(
	parameter int unsigned CYCLES = `PLC_FILTER_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_level,
	input wire logic i_enable,
	output logic o_level
);
	import plc_pkg::*;

	typedef struct packed {
		logic [7:0] count;
		logic stable;
	} plc_filt_state_t;

	plc_filt_state_t state;
	plc_filt_state_t next_state;

	initial begin
		if (CYCLES < 1 || CYCLES > 255) begin
			$error("plc_filter: CYCLES out of range");
		end
	end

	// ------------------------------------------------------------
	// filter state
	// ------------------------------------------------------------
	// bypass passes the raw level straight through the register
	always_comb begin
		next_state = state;
		if (!i_enable || i_level == state.stable) begin
			next_state.count = 8'h00;
			next_state.stable = i_level;
		end else if (state.count >= 8'(CYCLES - 1)) begin
			next_state.count = 8'h00;
			next_state.stable = i_level;
		end else begin
			next_state.count = state.count + 8'h01;
		end
	end

	// pins idle high under pull-up, so the filter starts high
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			state <= '{count: 8'h00, stable: 1'b1};
		end else begin
			state <= next_state;
		end
	end

	assign o_level = state.stable;
endmodule

// file: design/plc_params.svh
// constants, reset values and rule summary for the parallel line controller
//
// Behaviour
// RULE1: one instance drives up to 32 lines
// RULE2: line is general purpose or peripheral one/two
// RULE3: separate set and clear strobes change bits
// RULE4: change interrupt and glitch filter on every line
// RULE5: multi-drive lines drive low only, float high
// RULE6: per-line pull-up, software enabled or disabled
// RULE7: pin level readable at all times
// RULE8: one write sets and clears output lines together
// RULE9: general lines reset as inputs with pull-up
// RULE10: peripheral-reset lines reset owned, status one
// RULE11: peripheral-reset lines also reset with pull-up
// RULE12: instances report on source ids 2, 3, 4
// RULE13: unused wait-request pin reusable as general line
// RULE14: per-line select picks peripheral one or two
`ifndef PLC_PARAMS_SVH
`define PLC_PARAMS_SVH

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define PLC_PULLUP_RESET 32'hffff_ffff
`define PLC_OUT_RESET 32'h0000_0000
`define PLC_DIR_RESET 32'h0000_0000
`define PLC_SEL_RESET 32'h0000_0000

// ------------------------------------------------------------
// interrupt source identifiers of the three instances
// ------------------------------------------------------------
`define PLC_SRC_ID_PORT_A 5'h02
`define PLC_SRC_ID_PORT_B 5'h03
`define PLC_SRC_ID_PORT_C 5'h04

// ------------------------------------------------------------
// filter timing: a level must hold this long to pass
// ------------------------------------------------------------
`define PLC_CLK_MHZ 100
`define PLC_FILTER_NS 20
`define PLC_FILTER_CYCLES ((`PLC_FILTER_NS * `PLC_CLK_MHZ + 999) / 1000)

`endif

// file: design/plc_pkg.sv
// types shared by the parallel line controller
package plc_pkg;
	// configuration field selected by a set/clear strobe pair
	typedef enum logic [3:0] {
		plc_fld_own = 4'h0,
		plc_fld_dir = 4'h1,
		plc_fld_sel = 4'h2,
		plc_fld_pull = 4'h3,
		plc_fld_md = 4'h4,
		plc_fld_filt = 4'h5,
		plc_fld_ien = 4'h6,
		plc_fld_out = 4'h7
	} plc_field_t;
endpackage

// file: design/plc_port.sv
// parallel line controller: one port of up to 32 pins
`include "plc_params.svh"
module plc_port #(
	parameter int unsigned LINES = 32,
	parameter logic [31:0] OWN_RESET = 32'h0000_0000,
	parameter logic [4:0] SRC_ID = `PLC_SRC_ID_PORT_A
) (
	input wire logic i_clk,
	input wire logic i_reset,
	// configuration strobes, one field at a time
	input wire plc_pkg::plc_field_t i_field,
	input wire logic [LINES-1:0] i_set,
	input wire logic [LINES-1:0] i_clear,
	// synchronous output: one write sets and clears together
	input wire logic i_sync_write,
	input wire logic [LINES-1:0] i_sync_set,
	input wire logic [LINES-1:0] i_sync_clear,
	// software read or acknowledge of change events
	input wire logic i_change_ack,
	// pins
	input wire logic [LINES-1:0] i_pin,
	output logic [LINES-1:0] o_pin,
	output logic [LINES-1:0] o_pin_oe_n,
	output logic [LINES-1:0] o_pullup,
	// peripheral function one and two
	input wire logic [LINES-1:0] i_per1_out,
	input wire logic [LINES-1:0] i_per1_oe,
	input wire logic [LINES-1:0] i_per2_out,
	input wire logic [LINES-1:0] i_per2_oe,
	output logic [LINES-1:0] o_per1_in,
	output logic [LINES-1:0] o_per2_in,
	// status
	output logic [LINES-1:0] o_line_ownership_status,
	output logic [LINES-1:0] o_select_status,
	output logic [LINES-1:0] o_dir_status,
	output logic [LINES-1:0] o_pullup_status,
	output logic [LINES-1:0] o_multi_drive_status,
	output logic [LINES-1:0] o_filter_status,
	output logic [LINES-1:0] o_irq_enable_status,
	output logic [LINES-1:0] o_out_status,
	output logic [LINES-1:0] o_pin_level,
	output logic [LINES-1:0] o_change,
	output logic o_irq,
	output logic [4:0] o_src_id
);
	import plc_pkg::*;

	// ------------------------------------------------------------
	// reset patterns
	// ------------------------------------------------------------
	// the shared patterns are 32 wide; each is cut to the lines in use
	localparam logic [31:0] PULL_RST = `PLC_PULLUP_RESET;
	localparam logic [31:0] OUT_RST = `PLC_OUT_RESET;
	localparam logic [31:0] DIR_RST = `PLC_DIR_RESET;
	localparam logic [31:0] SEL_RST = `PLC_SEL_RESET;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [LINES-1:0] own;
		logic [LINES-1:0] sel;
		logic [LINES-1:0] dir;
		logic [LINES-1:0] pull;
		logic [LINES-1:0] md;
		logic [LINES-1:0] filt;
		logic [LINES-1:0] ien;
		logic [LINES-1:0] out;
		logic [LINES-1:0] pin_q;
		logic [LINES-1:0] last;
		logic [LINES-1:0] chg;
		logic [LINES-1:0] drv;
		logic [LINES-1:0] oe_n;
		logic [LINES-1:0] per1_in;
		logic [LINES-1:0] per2_in;
		logic irq;
		logic [4:0] src; // interrupt source id, held in a register
	} plc_port_state_t;

	plc_port_state_t state;
	plc_port_state_t next_state;
	logic [LINES-1:0] filtered;

	// ------------------------------------------------------------
	// elaboration check
	// ------------------------------------------------------------
	initial begin
		if (LINES < 1 || LINES > 32) begin
			$error("plc_port: LINES must be 1 to 32"); // RULE1
		end
		// ids 0 and 1 are taken by the fast input and the system block
		if (SRC_ID < 5'h02) begin
			$error("plc_port: SRC_ID must be 2 or above"); // RULE12
		end
		// an owned-at-reset bit past the last line would own nothing
		if ((OWN_RESET >> LINES) != 32'h0000_0000) begin
			$error("plc_port: OWN_RESET names lines past LINES"); // RULE10
		end
	end

	// ------------------------------------------------------------
	// helper functions
	// ------------------------------------------------------------
	// set wins over clear when both name the same bit
	function automatic logic [LINES-1:0] apply(input logic [LINES-1:0] cur, input logic [LINES-1:0] s,
		input logic [LINES-1:0] c);
		apply = (cur & ~c) | s;
	endfunction

	// per-line owner mux: a whole-vector select would hand every line to one owner
	function automatic logic [LINES-1:0] pick(input logic [LINES-1:0] own, input logic [LINES-1:0] sel,
		input logic [LINES-1:0] gp, input logic [LINES-1:0] p1, input logic [LINES-1:0] p2);
		pick = (~own & gp) | (own & ~sel & p1) | (own & sel & p2);
	endfunction

	// ------------------------------------------------------------
	// glitch filters, one per line
	// ------------------------------------------------------------
	// the filter works for owned and general lines alike
	generate
		for (genvar g = 0; g < LINES; g++) begin : g_filt
			plc_filter #(.CYCLES(`PLC_FILTER_CYCLES)) u_filt (
				.i_clk(i_clk),
				.i_reset(i_reset),
				.i_level(state.pin_q[g]),
				.i_enable(state.filt[g]),
				.o_level(filtered[g])
			); // RULE4
		end
	endgenerate

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		logic [LINES-1:0] d_out;
		logic [LINES-1:0] d_oe;
		logic [LINES-1:0] edge_seen;
		d_out = '0;
		d_oe = '0;
		edge_seen = '0;
		next_state = state;
		// per-field set/clear strobes leave other lines untouched
		case (i_field)
			plc_fld_own: next_state.own = apply(state.own, i_set, i_clear); // RULE3 RULE2
			plc_fld_dir: next_state.dir = apply(state.dir, i_set, i_clear); // RULE3
			plc_fld_sel: next_state.sel = apply(state.sel, i_set, i_clear); // RULE14
			plc_fld_pull: next_state.pull = apply(state.pull, i_set, i_clear); // RULE6
			plc_fld_md: next_state.md = apply(state.md, i_set, i_clear); // RULE5
			plc_fld_filt: next_state.filt = apply(state.filt, i_set, i_clear); // RULE4
			plc_fld_ien: next_state.ien = apply(state.ien, i_set, i_clear); // RULE4
			plc_fld_out: next_state.out = apply(state.out, i_set, i_clear); // RULE3
			default: next_state.own = state.own;
		endcase
		// single write drives some lines high and others low at once
		if (i_sync_write) begin
			next_state.out = apply(next_state.out, i_sync_set, i_sync_clear); // RULE8
		end
		// pins are sampled every cycle whatever the direction or owner
		next_state.pin_q = i_pin; // RULE7
		next_state.last = filtered;
		// change events are sticky; a new edge beats the acknowledge
		edge_seen = filtered ^ state.last;
		next_state.chg = (i_change_ack ? '0 : state.chg) | edge_seen; // RULE4
		next_state.irq = |(next_state.chg & next_state.ien); // mask as it will stand, so irq matches the flags
		// owner picks the driver: the select chooses between peripherals
		d_out = pick(state.own, state.sel, state.out, i_per1_out, i_per2_out); // RULE2 RULE14
		d_oe = pick(state.own, state.sel, state.dir, i_per1_oe, i_per2_oe); // RULE2 RULE14
		// multi-drive lines only pull low; a high is left to the pull-up
		next_state.drv = d_out & ~state.md; // RULE5
		next_state.oe_n = ~(d_oe & ~(state.md & d_out)); // RULE5
		// inputs reach only the selected peripheral, others see idle high
		next_state.per1_in = filtered | ~(state.own & ~state.sel); // RULE14
		next_state.per2_in = filtered | ~(state.own & state.sel); // RULE14
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	// owned lines and general lines both come up with pull-up on
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			state.own <= OWN_RESET[LINES-1:0]; // RULE9 RULE10
			state.sel <= SEL_RST[LINES-1:0];
			state.dir <= DIR_RST[LINES-1:0]; // RULE9
			state.pull <= PULL_RST[LINES-1:0]; // RULE9 RULE11
			state.md <= '0;
			state.filt <= '0;
			state.ien <= '0;
			state.out <= OUT_RST[LINES-1:0];
			state.pin_q <= '1;
			state.last <= '1;
			state.chg <= '0;
			state.drv <= '0;
			state.oe_n <= '1;
			state.per1_in <= '1;
			state.per2_in <= '1;
			state.irq <= 1'b0;
			state.src <= SRC_ID; // RULE12
		end else begin
			state <= next_state;
		end
	end

	// ------------------------------------------------------------
	// outputs, all straight from flip-flops
	// ------------------------------------------------------------
	assign o_pin = state.drv;
	assign o_pin_oe_n = state.oe_n;
	assign o_pullup = state.pull; // RULE6
	assign o_per1_in = state.per1_in;
	assign o_per2_in = state.per2_in;
	assign o_line_ownership_status = state.own; // RULE10
	assign o_select_status = state.sel;
	assign o_dir_status = state.dir;
	assign o_pullup_status = state.pull;
	assign o_multi_drive_status = state.md;
	assign o_filter_status = state.filt;
	assign o_irq_enable_status = state.ien;
	assign o_out_status = state.out;
	assign o_pin_level = state.pin_q; // RULE7
	assign o_change = state.chg;
	assign o_irq = state.irq;
	// the id sits in a register so every output leaves a flip-flop
	assign o_src_id = state.src; // RULE12
endmodule

// file: verification/plc_board.sv
// board side of the pins: pads, pull-ups and outside drivers
module plc_board (
	input wire logic i_clk,
	input wire logic [31:0] i_drv,
	input wire logic [31:0] i_drv_oe_n,
	input wire logic [31:0] i_pull,
	input wire logic [31:0] i_ext,
	input wire logic [31:0] i_ext_en,
	output logic [31:0] o_pad
);
	timeunit 1ns;
	timeprecision 1ps;
	logic tog = 1'b0;
	// a floating pad wanders, so a stale level never looks valid
	always @(posedge i_clk) tog <= ~tog;
	assign o_pad = (~i_drv_oe_n & i_drv) | (i_drv_oe_n & i_ext_en & i_ext)
		| (i_drv_oe_n & ~i_ext_en & (i_pull | {16{tog, ~tog}}));
endmodule

// file: verification/plc_port_asserts.sv
// port-level checks for one line controller
module plc_port_asserts #(
	parameter int unsigned LINES = 32,
	parameter logic [4:0] SRC_ID = 5'h02
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire plc_pkg::plc_field_t i_field,
	input wire logic [LINES-1:0] i_set,
	input wire logic [LINES-1:0] i_clear,
	input wire logic i_sync_write,
	input wire logic [LINES-1:0] i_sync_set,
	input wire logic [LINES-1:0] i_pin,
	input wire logic [LINES-1:0] o_pin,
	input wire logic [LINES-1:0] o_pin_oe_n,
	input wire logic [LINES-1:0] o_line_ownership_status,
	input wire logic [LINES-1:0] o_dir_status,
	input wire logic [LINES-1:0] o_pullup_status,
	input wire logic [LINES-1:0] o_multi_drive_status,
	input wire logic [LINES-1:0] o_irq_enable_status,
	input wire logic [LINES-1:0] o_out_status,
	input wire logic [LINES-1:0] o_pin_level,
	input wire logic [LINES-1:0] o_change,
	input wire logic o_irq,
	input wire logic [4:0] o_src_id
);
	timeunit 1ns;
	timeprecision 1ps;
	import plc_pkg::*;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	// ----------
	// assertions
	// ----------
	a_src_id_fixed: assert property (o_src_id == SRC_ID) else $error("src id");
	a_pull_setclr: assert property (i_field == plc_fld_pull |=>
		(o_pullup_status & $past(i_set)) == $past(i_set) && (o_pullup_status & $past(i_clear & ~i_set)) == '0)
		else $error("pull set/clear");
	a_dir_untouched: assert property (i_field == plc_fld_dir |=>
		((o_dir_status ^ $past(o_dir_status)) & ~$past(i_set | i_clear)) == '0) else $error("dir other bits");
	a_sync_out_set: assert property (i_sync_write |=>
		(o_out_status & $past(i_sync_set)) == $past(i_sync_set)) else $error("sync set");
	a_open_drain_high: assert property (!(o_multi_drive_status & $past(o_multi_drive_status)
		& o_pin & ~o_pin_oe_n)) else $error("open drain drove high");
	a_level_follows: assert property (!$past(i_reset) |-> o_pin_level == $past(i_pin)) else $error("level");
	a_irq_from_flags: assert property (o_irq == |(o_change & o_irq_enable_status)) else $error("irq");
	// a general output line not in multi-drive drives the last registered output value
	a_gpio_drive: assert property ((($past(o_dir_status & ~o_line_ownership_status & ~o_multi_drive_status)
		& (o_pin_oe_n | (o_pin ^ $past(o_out_status))))) == '0) else $error("gpio drive");
	cover property (o_irq);
	cover property (i_sync_write);
	cover property (i_field == plc_fld_md && |i_set);
endmodule

// file: verification/tb_parallel_io_line_controller.sv
// self-checking bench for one line controller port
module tb_parallel_io_line_controller;
	timeunit 1ns;
	timeprecision 1ps;
	import plc_pkg::*;
	localparam int unsigned LINES = 32;
	localparam logic [31:0] OWN_RESET = 32'hc000_0000;
	localparam logic [4:0] SRC_ID = 5'h02;
	typedef struct {plc_field_t f; logic [31:0] s, c, e;} plc_row_t;
	logic i_clk = 1'b0, i_reset = 1'b1, i_sync_write = 1'b0, i_change_ack = 1'b0, o_irq;
	plc_field_t i_field = plc_fld_own;
	logic [31:0] i_set = 32'h0, i_clear = 32'h0, i_sync_set = 32'h0, i_sync_clear = 32'h0, i_pin, o_pin, o_pin_oe_n;
	logic [31:0] i_per1_out = 32'h0, i_per1_oe = 32'hffff_ffff, i_per2_out = 32'hffff_ffff, i_per2_oe = 32'hffff_ffff;
	logic [31:0] o_line_ownership_status, o_select_status, o_dir_status, o_pullup_status, o_multi_drive_status;
	logic [31:0] o_filter_status, o_irq_enable_status, o_out_status, o_pin_level, o_change, o_pullup, o_per1_in, o_per2_in;
	logic [31:0] ext = 32'h0, ext_en = 32'h0000_00fc;
	logic [4:0] o_src_id;
	int errors = 0, tests_run = 0;
	// one row per field code, two for dir: strobes and the status they should leave
	plc_row_t rows [9] = '{'{plc_fld_own, 32'h3, 32'hc000_0000, 32'h3}, '{plc_fld_sel, 32'h2, 32'h0, 32'h2},
		'{plc_fld_pull, 32'h0, 32'hff, 32'hffff_ff00}, '{plc_fld_dir, 32'hf00, 32'h0, 32'hf00},
		'{plc_fld_md, 32'hc00, 32'h0, 32'hc00}, '{plc_fld_out, 32'h500, 32'h0, 32'h500},
		'{plc_fld_ien, 32'hffff_ffff, 32'h0, 32'hffff_ffff}, '{plc_fld_filt, 32'h1, 32'h0, 32'h1},
		'{plc_fld_dir, 32'h1000, 32'h1000, 32'h1f00}};
	plc_port #(.LINES(LINES), .OWN_RESET(OWN_RESET), .SRC_ID(SRC_ID)) i_dut (.i_clk, .i_reset, .i_field, .i_set,
		.i_clear, .i_sync_write, .i_sync_set, .i_sync_clear, .i_change_ack, .i_pin, .o_pin, .o_pin_oe_n, .o_pullup,
		.i_per1_out, .i_per1_oe, .i_per2_out, .i_per2_oe, .o_per1_in, .o_per2_in, .o_line_ownership_status,
		.o_select_status, .o_dir_status, .o_pullup_status, .o_multi_drive_status, .o_filter_status,
		.o_irq_enable_status, .o_out_status, .o_pin_level, .o_change, .o_irq, .o_src_id);
	plc_board i_board (.i_clk, .i_drv(o_pin), .i_drv_oe_n(o_pin_oe_n), .i_pull(o_pullup), .i_ext(ext),
		.i_ext_en(ext_en), .o_pad(i_pin));
	initial forever #5 i_clk = ~i_clk;
	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			errors++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	// status output that belongs to a field code
	function automatic logic [31:0] status_of(plc_field_t f);
		case (f)
			plc_fld_own: status_of = o_line_ownership_status;
			plc_fld_dir: status_of = o_dir_status;
			plc_fld_sel: status_of = o_select_status;
			plc_fld_pull: status_of = o_pullup_status;
			plc_fld_md: status_of = o_multi_drive_status;
			plc_fld_filt: status_of = o_filter_status;
			plc_fld_ien: status_of = o_irq_enable_status;
			default: status_of = o_out_status;
		endcase
	endfunction
	// strobes are held for one rising edge, then one idle edge passes
	task automatic op(plc_field_t f, logic [31:0] s, logic [31:0] c);
		i_field = f;
		i_set = s;
		i_clear = c;
		@(negedge i_clk);
		i_set = 32'h0;
		i_clear = 32'h0;
		@(negedge i_clk);
	endtask
	// acknowledge held for exactly one rising edge
	task automatic ack;
		i_change_ack = 1'b1;
		@(negedge i_clk);
		i_change_ack = 1'b0;
	endtask
	task automatic stop_test;
		if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// ----------
	// main sequence
	// ----------
	initial begin
		repeat (5) @(negedge i_clk);
		i_reset = 1'b0;
		chk("own", o_line_ownership_status, OWN_RESET);
		chk("pull", o_pullup_status, 32'hffff_ffff);
		chk("dir", o_dir_status, 32'h0);
		chk("oe", o_pin_oe_n, 32'hffff_ffff);
		chk("src", {27'h0, o_src_id}, 32'h2);
		foreach (rows[k]) begin
			op(rows[k].f, rows[k].s, rows[k].c);
			chk("field", status_of(rows[k].f), rows[k].e);
		end
		repeat (3) @(negedge i_clk);
		chk("oe", {20'h0, o_pin_oe_n[11:0]}, 32'h4fc);
		chk("level", {20'h0, o_pin_level[11:0]}, 32'h502);
		chk("per", {28'h0, o_per2_in[1:0], o_per1_in[1:0]}, 32'he);
		chk("pin", o_pin, 32'h0000_0102);
		chk("pullup", o_pullup, 32'hffff_ff00);
		i_sync_write = 1'b1;
		i_sync_set = 32'h200;
		i_sync_clear = 32'h100;
		@(negedge i_clk);
		i_sync_write = 1'b0;
		chk("sync", {28'h0, o_out_status[11:8]}, 32'h6);
		repeat (8) @(negedge i_clk);
		ack();
		chk("quiet", o_change, 32'h0);
		ext[4] = 1'b1;
		for (int k = 0; k < 10 && o_change !== 32'h10; k++) @(negedge i_clk);
		chk("change", o_change, 32'h10);
		chk("irq", {31'h0, o_irq}, 32'h1);
		op(plc_fld_ien, 32'h0, 32'h10);
		chk("masked", {31'h0, o_irq}, 32'h0);
		ack();
		chk("acked", o_change, 32'h0);
		// a one-cycle pulse must not pass an enabled filter; a held level passes two edges late
		op(plc_fld_filt, 32'h4, 32'h0);
		ext[2] = 1'b1;
		@(negedge i_clk);
		ext[2] = 1'b0;
		repeat (4) @(negedge i_clk);
		chk("glitch", o_change, 32'h0);
		ext[2] = 1'b1;
		repeat (3) @(negedge i_clk);
		chk("filter hold", o_change, 32'h0);
		@(negedge i_clk);
		chk("filtered", o_change, 32'h4);
		ack();
		// a line taken back from its reset owner serves as a general output
		chk("freed", {30'h0, o_pin_oe_n[30], o_pin[30]}, 32'h2);
		op(plc_fld_dir, 32'h4000_0000, 32'h0);
		chk("freed drive", {30'h0, o_pin_oe_n[30], o_pin[30]}, 32'h0);
		// a second reset in mid run restores every setting
		i_reset = 1'b1;
		repeat (2) @(negedge i_clk);
		i_reset = 1'b0;
		chk("own again", o_line_ownership_status, OWN_RESET);
		chk("pullup again", o_pullup, 32'hffff_ffff);
		chk("dir again", o_dir_status, 32'h0);
		chk("oe again", o_pin_oe_n, 32'hffff_ffff);
		chk("pin again", o_pin, 32'h0);
		chk("change again", o_change, 32'h0);
		chk("irq again", {31'h0, o_irq}, 32'h0);
		@(negedge i_clk);
		chk("owned drive", {30'h0, o_pin_oe_n[31:30]}, 32'h0);
		chk("src again", {27'h0, o_src_id}, 32'h2);
		stop_test();
	end
	// cut a hang short well past the expected run length
	initial begin
		#20000;
		errors++;
		stop_test();
	end
endmodule
bind plc_port plc_port_asserts #(.LINES(LINES), .SRC_ID(SRC_ID)) i_chk (.i_clk, .i_reset, .i_field, .i_set,
	.i_clear, .i_sync_write, .i_sync_set, .i_pin, .o_pin, .o_pin_oe_n, .o_line_ownership_status, .o_dir_status,
	.o_pullup_status, .o_multi_drive_status, .o_irq_enable_status, .o_out_status, .o_pin_level, .o_change,
	.o_irq, .o_src_id);
